// *** hdl/sdram_burst_engine.sv ***
/*
 Device-side command engine: burst read/write, interruptions, burst stop,
 auto-precharge, explicit precharge and self refresh.
 Assumes pins arrive from outside sys_clk and are synchronised here; the array
 itself sits outside on the write port and read-data port.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - CS and CAS low, RAS and WE high starts a read at column
// - Burst type and length come from programmed mode settings
// - CS, CAS, WE low with RAS high starts a write at column
// - Write data taken from command cycle for burst length; later ignored
// - New read restarts at new column; old data until new latency
// - Mask in read tristates two cycles later; in write blocks now
// - New write overrides remaining addresses with a full new burst
// - Read ends a write at once; leftover write data ignored
// - Burst stop ends a full-page burst and leaves bank open
// - Burst stop in read tristates outputs after CAS latency
// - Sequential order wraps in burst without carry from low bits
// - Interleaved order is start column XOR beat index
// - A10 selects auto-precharge; read precharges latency clocks early, never in a burst shorter than the latency
// - Write auto-precharge starts three clocks after last data
// - CS, RAS, WE low, CAS high is precharge
// - Self refresh entry with CKE low; other inputs then ignored
// - Self refresh held while CKE low, exits when it rises
module sdram_burst_engine
    import sdram_burst_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire sdram_burst_pkg::cmd_pins_s pins,
    input wire logic [sdram_burst_pkg::DATA_W-1:0] dq_in,
    output logic [sdram_burst_pkg::DATA_W-1:0] dq_out,
    output logic [1:0] dq_oe,
    input wire sdram_burst_pkg::mode_cfg_s mode,
    input wire logic [sdram_burst_pkg::BANKS-1:0] bank_open_set,
    output logic [sdram_burst_pkg::BANKS-1:0] bank_open,
    output logic [sdram_burst_pkg::BANKS-1:0] bank_precharge,
    output logic self_refresh,
    output logic [sdram_burst_pkg::COL_W-1:0] rd_col,
    output logic [1:0] rd_bank,
    output logic rd_strobe,
    input wire logic [sdram_burst_pkg::DATA_W-1:0] rd_data,
    output logic wr_valid,
    input wire logic wr_ready,
    output sdram_burst_pkg::wr_word_s wr_word,
    output logic wr_stall
);
    import sdram_burst_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b100
    } burst_st_e;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    cmd_pins_s pins_meta;
    cmd_pins_s p;
    logic [DATA_W-1:0] dq_meta;
    logic [DATA_W-1:0] dq_s;
    logic cke_prev;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pins_meta <= '{cs_b: 1'b1, ras_b: 1'b1, cas_b: 1'b1, we_b: 1'b1, default: '0};
            p <= '{cs_b: 1'b1, ras_b: 1'b1, cas_b: 1'b1, we_b: 1'b1, default: '0};
            dq_meta <= '0;
            dq_s <= '0;
            cke_prev <= 1'b0;
        end else begin
            pins_meta <= pins;
            p <= pins_meta;
            dq_meta <= dq_in;
            dq_s <= dq_meta;
            cke_prev <= p.cke;
        end
    end

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    logic sel;
    logic cmd_read;
    logic cmd_write;
    logic cmd_stop;
    logic cmd_pre;
    logic cmd_sref;
    logic [1:0] cmd_bank;
    logic [COL_W-1:0] cmd_col;
    logic ap_lock;

    // Self refresh and clock-enable low both gate the decoder
    assign sel = !p.cs_b && cke_prev && !self_refresh;
    assign cmd_bank = {p.bank_select_high, p.bank_select_low};
    assign cmd_col = p.addr[COL_W-1:0];
    // Reads, writes and precharges during an auto-precharge burst are refused, the controller must not send them
    assign cmd_read = sel && p.cke && p.ras_b && !p.cas_b && p.we_b && !ap_lock;
    assign cmd_write = sel && p.cke && p.ras_b && !p.cas_b && !p.we_b && !ap_lock;
    assign cmd_stop = sel && p.ras_b && p.cas_b && !p.we_b;
    assign cmd_pre = sel && !p.ras_b && p.cas_b && !p.we_b && !ap_lock;
    assign cmd_sref = sel && !p.cke && !p.ras_b && !p.cas_b && p.we_b
        && (bank_open == BANKS_NONE);

    // ----------------------------------------
    // Burst sequencer
    // ----------------------------------------
    burst_st_e state;
    logic [COL_W-1:0] start_col;
    logic [8:0] beat;
    logic [8:0] last_beat;
    logic [1:0] bank;
    logic auto_pre;
    logic [COL_W-1:0] beat_col;
    logic [COL_W-1:0] seq_col;
    logic [COL_W-1:0] low_mask;
    logic burst_end;

    always_comb begin
        case (mode.burst_len)
            BL_1: last_beat = 9'h000;
            BL_2: last_beat = 9'h001;
            BL_4: last_beat = 9'h003;
            BL_8: last_beat = 9'h007;
            default: last_beat = PAGE_LEN;
        endcase
    end

    assign low_mask = last_beat;
    assign seq_col = start_col + beat;
    // Sequential wraps only inside the burst-length bits
    always_comb begin
        if (mode.interleaved) begin
            beat_col = start_col ^ beat;
        end else begin
            beat_col = (start_col & ~low_mask) | (seq_col & low_mask);
        end
    end

    assign burst_end = (state != ST_IDLE) && (beat == last_beat);
    assign ap_lock = auto_pre && (state != ST_IDLE);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            start_col <= '0;
            beat <= '0;
            bank <= '0;
            auto_pre <= 1'b0;
        end else begin
            case (state)
                ST_IDLE, ST_READ, ST_WRITE: begin
                    if (cmd_read || cmd_write) begin
                        // A new command restarts with a full burst from its column
                        state <= cmd_read ? ST_READ : ST_WRITE;
                        start_col <= cmd_col;
                        beat <= '0;
                        bank <= cmd_bank;
                        auto_pre <= p.addr[AP_BIT];
                    end else if (cmd_stop && mode.burst_len == BL_PAGE) begin
                        state <= ST_IDLE;
                        auto_pre <= 1'b0;
                    end else if (state != ST_IDLE && !(wr_stall && state == ST_WRITE)) begin
                        if (burst_end) begin
                            state <= ST_IDLE;
                            auto_pre <= 1'b0;
                        end else begin
                            beat <= beat + 9'h001;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Write path through the FIFO
    // ----------------------------------------
    logic wr_push;
    wr_word_s wr_in;
    logic fifo_in_ready;
    logic [8:0] next_beat;
    logic [COL_W-1:0] next_seq_col;
    logic [COL_W-1:0] next_beat_col;

    // Column of the word that the controller presents in this beat
    assign next_beat = beat + 9'h001;
    assign next_seq_col = start_col + next_beat;
    assign next_beat_col = mode.interleaved ? (start_col ^ next_beat)
        : ((start_col & ~low_mask) | (next_seq_col & low_mask));

    // Beats beyond the burst never reach the FIFO
    assign wr_push = (cmd_write || (state == ST_WRITE && !cmd_read && !cmd_stop
        && !burst_end)) && p.dqm == 2'h0;
    assign wr_in.col = cmd_write ? cmd_col : next_beat_col;
    assign wr_in.bank = cmd_write ? cmd_bank : bank;
    assign wr_in.data = dq_s;
    assign wr_in.mask = p.dqm;
    // A full FIFO holds the burst counter, so a slow array back-pressures the stream
    assign wr_stall = !fifo_in_ready;

    sdram_word_fifo #(
        .WIDTH($bits(wr_word_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .in_valid(wr_push),
        .in_ready(fifo_in_ready),
        .in_data(wr_in),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(wr_word)
    );

    // ----------------------------------------
    // Read data pipeline
    // ----------------------------------------
    logic [3:0] rd_pipe;
    logic [3:0] stop_pipe;
    logic [1:0] mask_d1;
    logic [1:0] mask_d2;
    logic [1:0] lat_sel;
    logic [DATA_W-1:0] rd_hist [3];

    // Array fetch issued every beat of a read
    assign rd_strobe = (state == ST_READ);
    assign rd_col = beat_col;
    assign rd_bank = bank;
    assign lat_sel = (mode.cas_latency < CAS_MIN) ? CAS_MIN : mode.cas_latency;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_pipe <= '0;
            stop_pipe <= '0;
            mask_d1 <= '0;
            mask_d2 <= '0;
            rd_hist <= '{default: '0};
            dq_out <= '0;
            dq_oe <= '0;
        end else begin
            // Old data keeps flowing until the new latency is reached
            rd_pipe <= {rd_pipe[2:0], rd_strobe};
            stop_pipe <= {stop_pipe[2:0], cmd_stop || cmd_write};
            mask_d1 <= p.dqm;
            mask_d2 <= mask_d1;
            // Data rides the same delay as its enable, so each beat meets its own window
            rd_hist[0] <= rd_data;
            rd_hist[1] <= rd_hist[0];
            rd_hist[2] <= rd_hist[1];
            dq_out <= rd_hist[lat_sel - 2'h1];
            if (stop_pipe[lat_sel - 2'h1]) begin
                dq_oe <= '0;
            end else if (rd_pipe[lat_sel - 2'h1]) begin
                dq_oe <= ~mask_d2;
            end else begin
                dq_oe <= '0;
            end
        end
    end

    // ----------------------------------------
    // Banks, precharge and self refresh
    // ----------------------------------------
    logic [1:0] wr_ap_cnt;
    logic [1:0] wr_ap_bank;
    logic [BANKS-1:0] pre_vec;
    logic rd_ap_fire;

    // Read precharge begins CAS latency beats before the burst ends; a burst shorter than the latency never precharges
    assign rd_ap_fire = state == ST_READ && auto_pre
        && (beat + {7'h00, lat_sel} == last_beat + 9'h001);

    always_comb begin
        pre_vec = BANKS_NONE;
        if (cmd_pre) begin
            pre_vec = p.addr[AP_BIT] ? BANKS_ALL : (BANKS)'(1 << cmd_bank);
        end
        if (rd_ap_fire) begin
            pre_vec = pre_vec | (BANKS)'(1 << bank);
        end
        if (wr_ap_cnt == 2'h1) begin
            pre_vec = pre_vec | (BANKS)'(1 << wr_ap_bank);
        end
    end

    assign bank_precharge = pre_vec;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ap_cnt <= '0;
            wr_ap_bank <= '0;
        end else if (state == ST_WRITE && auto_pre && burst_end) begin
            wr_ap_cnt <= 2'(WR_AP_DELAY);
            wr_ap_bank <= bank;
        end else if (wr_ap_cnt != 2'h0) begin
            wr_ap_cnt <= wr_ap_cnt - 2'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bank_open <= BANKS_NONE;
        end else begin
            bank_open <= (bank_open | bank_open_set) & ~pre_vec;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            self_refresh <= 1'b0;
        end else if (cmd_sref) begin
            self_refresh <= 1'b1;
        end else if (self_refresh && p.cke) begin
            self_refresh <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** hdl/sdram_burst_pkg.sv ***
/*
 Shared constants and carriers for the SDRAM burst, precharge and self-refresh engine.
 Assumes one device clock (sys_clk) on which every pin is sampled.
*/
package sdram_burst_pkg;
    localparam int COL_W = 9;
    localparam int ROW_ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int BANKS = 4;
    localparam int AP_BIT = 10;
    localparam int FIFO_DEPTH = 4;
    localparam int MASK_LAT = 2;
    localparam int WR_AP_DELAY = 2;
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [8:0] PAGE_LEN = 9'h1FF;
    localparam logic [1:0] CAS_MIN = 2'h1;
    localparam logic [3:0] BANKS_ALL = 4'hF;
    localparam logic [3:0] BANKS_NONE = 4'h0;

    typedef struct packed {
        logic cs_b;
        logic ras_b;
        logic cas_b;
        logic we_b;
        logic cke;
        logic [1:0] dqm;
        logic bank_select_high;
        logic bank_select_low;
        logic [ROW_ADDR_W-1:0] addr;
    } cmd_pins_s;

    typedef struct packed {
        logic [1:0] cas_latency;
        logic interleaved;
        logic [2:0] burst_len;
    } mode_cfg_s;

    typedef struct packed {
        logic [COL_W-1:0] col;
        logic [1:0] bank;
        logic [DATA_W-1:0] data;
        logic [1:0] mask;
    } wr_word_s;
endpackage

// *** hdl/sdram_word_fifo.sv ***
/*
 Small flip-flop FIFO with valid/ready on both sides.
 Assumes a single clock; storage indexed by pointers.
*/
`timescale 1ns/1ps
`default_nettype none
module sdram_word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// *** verif/sdram_burst_chk.sv ***
/* Port checker for the burst engine, bound to it below.
 Assumes mode stays static within a burst. */
`timescale 1ns/1ps
`default_nettype none
module sdram_burst_chk
    import sdram_burst_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire sdram_burst_pkg::cmd_pins_s pins,
    input wire logic [1:0] dq_oe,
    input wire sdram_burst_pkg::mode_cfg_s mode,
    input wire logic [3:0] bank_open,
    input wire logic self_refresh,
    input wire logic [8:0] rd_col,
    input wire logic rd_strobe,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire sdram_burst_pkg::wr_word_s wr_word
);
    // ------
    // Properties
    // ------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic pre;
    assign pre = !pins.cs_b && !pins.ras_b && pins.cas_b && !pins.we_b && pins.cke;
    wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_word))
        else $error("stalled write word changed");
    mask_drop_a: assert property (wr_valid |-> wr_word.mask == 2'h0)
        else $error("masked beat reached the array");
    dq_off_a: assert property ((pins.dqm == 2'h3) [*6] |=> dq_oe == 2'h0)
        else $error("outputs driven under mask");
    sref_exit_a: assert property ($rose(pins.cke) && self_refresh
        |-> ##[1:4] !self_refresh) else $error("self refresh not left");
    sref_idle_a: assert property ($rose(self_refresh) |-> $past(bank_open) == BANKS_NONE)
        else $error("self refresh with a bank open");
    pre_all_a: assert property (pre && $past(pins.cke) && pins.addr[AP_BIT]
        |-> ##[1:5] bank_open == BANKS_NONE) else $error("precharge all left a bank open");
    seq_wrap_a: assert property (rd_strobe && $past(rd_strobe) && !mode.interleaved
        && mode.burst_len == BL_4 |-> rd_col == {$past(rd_col[8:2]), $past(rd_col[1:0]) + 2'h1})
        else $error("sequential column step wrong");
    ilv_step_a: assert property (rd_strobe && $past(rd_strobe) && mode.interleaved
        && mode.burst_len == BL_8 |-> (rd_col ^ $past(rd_col)) inside {9'h001, 9'h003, 9'h007})
        else $error("interleaved column step wrong");
endmodule
bind sdram_burst_engine sdram_burst_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .pins(pins),
    .dq_oe(dq_oe), .mode(mode), .bank_open(bank_open), .self_refresh(self_refresh),
    .rd_col(rd_col), .rd_strobe(rd_strobe), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_word(wr_word));
`default_nettype wire

// *** verif/sdram_ctrl_model.sv ***
/* Controller model driving the device pins, one command per call.
 Assumes one caller; pins change just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_model
    import sdram_burst_pkg::*;
(
    input wire logic sys_clk,
    output sdram_burst_pkg::cmd_pins_s pins,
    output logic [sdram_burst_pkg::DATA_W-1:0] dq_in
);
    // ------
    // Codes {cs_b, ras_b, cas_b, we_b}
    // ------
    localparam logic [3:0] C_NOP = 4'h7;
    localparam logic [3:0] C_RD = 4'h5;
    localparam logic [3:0] C_WR = 4'h4;
    localparam logic [3:0] C_STOP = 4'h6;
    localparam logic [3:0] C_PRE = 4'h2;
    localparam logic [3:0] C_SREF = 4'h1;
    // Stop only in page mode, no command inside an auto-precharge burst
    // Banks reopened before access, no write over a read, no bunched refresh
    initial begin
        pins = {C_NOP, 1'b1, 2'h3, 14'h0000};
        dq_in = 16'h0000;
    end
    task automatic send(input logic [3:0] c, input logic cke, input logic [1:0] bank,
        input logic [11:0] addr, input logic [1:0] dqm, input logic [15:0] d);
        @(posedge sys_clk);
        pins <= {c, cke, dqm, bank, addr};
        dq_in <= d;
    endtask
    // Released data shows the inverse so stale values never match
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            pins <= {C_NOP, pins.cke, pins.dqm, 14'h0000};
            dq_in <= ~dq_in;
        end
    endtask
    // First word rides with the command, one more per edge
    task automatic write_burst(input logic [8:0] col, input int n, input int masked,
        input logic [15:0] base);
        for (int i = 0; i < n; i++)
            send(i == 0 ? C_WR : C_NOP, 1'b1, 2'h2, i == 0 ? {3'h0, col} : 12'h000,
                i == masked ? 2'h3 : 2'h0, base + 16'(i));
    endtask
endmodule
`default_nettype wire

// *** verif/sdram_burst_engine_tb.sv ***
/* Self-checking bench: controller model on the pins, array stand-in on the far ports.
 Assumes the checker binds itself to the engine. */
`timescale 1ns/1ps
`default_nettype none
module sdram_burst_engine_tb;
    import sdram_burst_pkg::*;
    // ------
    // Signals and instances
    // ------
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr_ready = 1'b0;
    logic [3:0] bank_open_set = 4'h0;
    logic [15:0] last_rd = 16'h0000;
    logic [3:0] last_pre = 4'h0;
    mode_cfg_s mode = '0;
    cmd_pins_s pins;
    wr_word_s wr_word;
    wr_word_s log_q[$];
    logic [15:0] dq_in, dq_out, rd_data;
    logic [1:0] dq_oe, rd_bank;
    logic [3:0] bank_open, bank_precharge;
    logic [8:0] rd_col;
    logic self_refresh, rd_strobe, wr_valid, wr_stall;
    int err_count = 0;
    int checked = 0;
    initial forever #4 sys_clk = ~sys_clk;
    sdram_ctrl_model ctrl (.sys_clk(sys_clk), .pins(pins), .dq_in(dq_in));
    sdram_burst_engine dut (.sys_clk(sys_clk), .rst_b(rst_b), .pins(pins), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .mode(mode), .bank_open_set(bank_open_set),
        .bank_open(bank_open), .bank_precharge(bank_precharge), .self_refresh(self_refresh),
        .rd_col(rd_col), .rd_bank(rd_bank), .rd_strobe(rd_strobe), .rd_data(rd_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word), .wr_stall(wr_stall));
    // Array stand-in answers at once; idle data is the inverse of the last word
    assign rd_data = rd_strobe ? {rd_bank, 5'h00, rd_col} : ~last_rd;
    always @(posedge sys_clk) begin
        if (rd_strobe)
            last_rd <= rd_data;
        if (wr_valid && wr_ready)
            log_q.push_back(wr_word);
        if (bank_precharge != 4'h0)
            last_pre <= bank_precharge;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        ctrl.idle(n);
        #1;
    endtask
    task automatic open_banks(input logic [3:0] m);
        @(posedge sys_clk);
        bank_open_set <= m;
        @(posedge sys_clk);
        bank_open_set <= 4'h0;
    endtask
    task automatic t_read(input logic [1:0] cl, input logic ilv, input logic [2:0] bl,
        input logic [8:0] col);
        int k;
        logic [8:0] m;
        logic [8:0] e;
        m = 9'((1 << bl) - 1);
        open_banks(4'h2);
        mode <= {cl, ilv, bl};
        ctrl.send(ctrl.C_RD, 1'b1, 2'h1, {3'h0, col}, 2'h0, 16'h0000);
        k = 0;
        tick(1);
        while (dq_oe !== 2'h3 && k < 20) begin
            tick(1);
            k++;
        end
        check("read start", k < 20, 1'b1);
        for (int i = 0; i <= m; i++) begin
            e = ilv ? col ^ 9'(i) : (col & ~m) | ((col + 9'(i)) & m);
            check("read word", dq_out, {2'h1, 5'h00, e});
            tick(1);
        end
        check("read end", dq_oe, 2'h0);
        $display("read test done");
    endtask
    task automatic t_stop();
        @(posedge sys_clk);
        mode <= {2'h3, 1'b0, BL_PAGE};
        ctrl.send(ctrl.C_RD, 1'b1, 2'h1, 12'h000, 2'h0, 16'h0000);
        tick(12);
        check("page running", dq_oe, 2'h3);
        ctrl.send(ctrl.C_STOP, 1'b1, 2'h0, 12'h000, 2'h0, 16'h0000);
        tick(8);
        check("stop tristate", dq_oe, 2'h0);
        check("bank kept", bank_open[1], 1'b1);
        $display("stop test done");
    endtask
    task automatic t_write();
        logic [8:0] ec[9];
        logic [15:0] ed[9];
        wr_word_s w;
        ec = '{9'h00E, 9'h00F, 9'h00C, 9'h00D, 9'h010, 9'h011, 9'h021, 9'h023, 9'h020};
        ed = '{16'h1000, 16'h1001, 16'h1002, 16'h1003, 16'h2000, 16'h2001, 16'h3000,
            16'h3002, 16'h3003};
        @(posedge sys_clk);
        mode <= {2'h2, 1'b0, BL_4};
        wr_ready <= 1'b0;
        ctrl.write_burst(9'h00E, 4, 9, 16'h1000);
        tick(8);
        check("fifo full", {wr_stall, wr_valid}, 2'h3);
        @(posedge sys_clk);
        wr_ready <= 1'b1;
        tick(6);
        check("fifo empty", wr_valid, 1'b0);
        ctrl.write_burst(9'h010, 2, 9, 16'h2000);
        ctrl.write_burst(9'h021, 4, 1, 16'h3000);
        tick(10);
        check("word count", log_q.size(), 9);
        for (int i = 0; i < 9 && i < log_q.size(); i++) begin
            w = log_q[i];
            check("write word", {w.bank, w.col, w.data}, {2'h2, ec[i], ed[i]});
        end
        $display("write test done");
    endtask
    task automatic t_autopre();
        open_banks(4'h6);
        mode <= {2'h2, 1'b0, BL_4};
        ctrl.send(ctrl.C_RD, 1'b1, 2'h1, 12'h403, 2'h0, 16'h0000);
        tick(12);
        check("read precharge", {bank_open, last_pre}, 8'h42);
        ctrl.send(ctrl.C_WR, 1'b1, 2'h2, 12'h400, 2'h0, 16'h4000);
        tick(12);
        check("write precharge", {bank_open, last_pre}, 8'h04);
        $display("auto-precharge test done");
    endtask
    task automatic t_pre();
        open_banks(4'hF);
        tick(3);
        check("banks open", bank_open, 4'hF);
        ctrl.send(ctrl.C_PRE, 1'b1, 2'h2, 12'h000, 2'h0, 16'h0000);
        tick(6);
        check("one closed", bank_open, 4'hB);
        ctrl.send(ctrl.C_PRE, 1'b1, 2'h1, 12'h400, 2'h0, 16'h0000);
        tick(6);
        check("all closed", bank_open, 4'h0);
        $display("precharge test done");
    endtask
    task automatic t_sref();
        open_banks(4'h1);
        ctrl.send(ctrl.C_SREF, 1'b0, 2'h0, 12'h000, 2'h0, 16'h0000);
        tick(6);
        check("entry refused", self_refresh, 1'b0);
        ctrl.send(ctrl.C_NOP, 1'b1, 2'h0, 12'h000, 2'h0, 16'h0000);
        ctrl.send(ctrl.C_PRE, 1'b1, 2'h0, 12'h400, 2'h0, 16'h0000);
        tick(6);
        ctrl.send(ctrl.C_SREF, 1'b0, 2'h0, 12'h000, 2'h0, 16'h0000);
        tick(6);
        check("entered", self_refresh, 1'b1);
        ctrl.send(ctrl.C_RD, 1'b0, 2'h1, 12'h000, 2'h0, 16'h0000);
        tick(8);
        check("read ignored", {self_refresh, dq_oe}, 3'h4);
        ctrl.send(ctrl.C_NOP, 1'b1, 2'h0, 12'h000, 2'h0, 16'h0000);
        tick(6);
        check("left", self_refresh, 1'b0);
        $display("self refresh test done");
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Whole run is under 1000 cycles; 5000 leaves room for slow answers
    initial begin
        #40000;
        err_count++;
        report_and_stop();
    end
    initial begin
        tick(19);
        @(posedge sys_clk);
        rst_b <= 1'b1;
        wr_ready <= 1'b1;
        tick(8);
        t_read(2'h1, 1'b0, BL_1, 9'h0A3);
        t_read(2'h2, 1'b0, BL_2, 9'h0A3);
        t_read(2'h3, 1'b0, BL_4, 9'h006);
        t_read(2'h2, 1'b0, BL_8, 9'h0FD);
        t_read(2'h1, 1'b1, BL_4, 9'h006);
        t_read(2'h3, 1'b1, BL_8, 9'h105);
        t_stop();
        t_write();
        t_autopre();
        t_pre();
        t_sref();
        report_and_stop();
    end
endmodule
`default_nettype wire
